// ### rtl/lvpm_regs.sv
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - the warning flag sets while the supply is below the warning trip point, also right after reset.
// - the warning flag in bit 7 stays set until software acknowledges it.
// - writing 1 to the warning acknowledge bit clears the flag only when the warning has gone.
// - with the warning interrupt enable set, an interrupt is requested while the flag is set.
// - the write-once reset enable makes a detect event request a full reset while detect is on.
// - the write-once stop enable keeps detection running in stop mode when set.
// - the write-once detect enable turns detection on and qualifies reset and stop enables.
// - bit 0 of the first register enables the bandgap reference buffer.
// - each write-once bit in control one and the power-down control takes only the first write after any reset and ignores later ones.
// - the detect-voltage select takes one write after power-on reset only.
// - the detect-voltage select picks the low range at 0 and the high range at 1.
// - the warning-voltage select picks the lower or higher warning point inside the range.
// - the partial power-down flag reads 1 after waking from the deep stop mode.
// - writing 1 to the partial power-down acknowledge clears that flag; the bit reads 0.
// - the write-once power-down control picks deep stop when set, light stop when cleared.
module lvpm_regs
	import lvpm_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic power_on_reset,
	input wire logic [LVPM_ADDR_W-1:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic warning_below,
	input wire logic detect_below,
	input wire logic stop_mode_active,
	input wire logic deep_stop_wake,
	output logic irq,
	output logic low_detect_reset_req,
	output logic low_detect_active,
	output logic bandgap_buffer_enable,
	output logic detect_voltage_select,
	output logic warning_voltage_select,
	output logic deep_stop_select
);

	lvpm_state_t st;
	lvpm_state_t nx;

	logic wr_c1;
	logic wr_c2;
	logic wr_is;
	logic wr_im;
	logic [7:0] rd_mux;
	logic [LVPM_IRQ_W-1:0] ev;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign wr_c1 = wr_en && (addr == LVPM_OFS_CTL1);
	assign wr_c2 = wr_en && (addr == LVPM_OFS_CTL2);
	assign wr_is = wr_en && (addr == LVPM_OFS_ISTAT);
	assign wr_im = wr_en && (addr == LVPM_OFS_IMASK);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nx = st;
		rd_mux = 8'h00;
		ev = LVPM_RST_IRQ;

		// comparator levels cross into the clock domain
		nx.warn_meta = warning_below;
		nx.warn_sync = st.warn_meta;
		nx.det_meta = detect_below;
		nx.det_sync = st.det_meta;
		nx.warn_prev = st.warn_sync;
		nx.det_prev = st.det_sync;

		// warning flag: acknowledge only once the condition is gone
		if (wr_c1 && wr_data[LVPM_C1_WARN_ACK] && !st.warn_sync) begin
			nx.low_warning_flag = 1'b0;
		end
		if (st.warn_sync) begin
			nx.low_warning_flag = 1'b1;
		end

		// control one: freely writable bits
		if (wr_c1) begin
			nx.low_warning_irq_enable = wr_data[LVPM_C1_WARN_IE];
			nx.bandgap_buffer_enable = wr_data[LVPM_C1_BG_EN];
		end

		// control one: write-once detect configuration
		if (wr_c1 && !st.lock_one) begin
			nx.low_detect_reset_enable = wr_data[LVPM_C1_DET_RE];
			nx.low_detect_stop_enable = wr_data[LVPM_C1_DET_SE];
			nx.low_detect_enable = wr_data[LVPM_C1_DET_EN];
			nx.lock_one = 1'b1;
		end

		// control two: voltage selects
		if (wr_c2) begin
			nx.warning_voltage_select = wr_data[LVPM_C2_WARN_VSEL];
		end
		if (wr_c2 && !st.lock_vsel) begin
			nx.detect_voltage_select = wr_data[LVPM_C2_DET_VSEL];
			nx.lock_vsel = 1'b1;
		end

		// control two: write-once stop mode choice
		if (wr_c2 && !st.lock_two) begin
			nx.partial_powerdown_control = wr_data[LVPM_C2_PPD_CTL];
			nx.lock_two = 1'b1;
		end

		// partial power-down flag: wake sets, acknowledge clears
		if (wr_c2 && wr_data[LVPM_C2_PPD_ACK]) begin
			nx.partial_powerdown_flag = 1'b0;
		end
		if (deep_stop_wake) begin
			nx.partial_powerdown_flag = 1'b1;
		end

		// detection runs when enabled, and in stop only if allowed
		nx.detect_active = nx.low_detect_enable &&
			(!stop_mode_active || nx.low_detect_stop_enable);
		nx.reset_req = nx.detect_active && nx.low_detect_reset_enable &&
			st.det_sync;

		// sticky events, set wins over write-one-to-clear
		ev[LVPM_EV_WARN] = st.warn_sync && !st.warn_prev;
		ev[LVPM_EV_DETECT] = st.det_sync && !st.det_prev && st.detect_active;
		ev[LVPM_EV_PPD] = deep_stop_wake;
		if (wr_is) begin
			nx.int_status = st.int_status & ~wr_data[LVPM_IRQ_W-1:0];
		end
		nx.int_status = nx.int_status | ev;
		if (wr_im) begin
			nx.int_mask = wr_data[LVPM_IRQ_W-1:0];
		end
		nx.irq = (nx.low_warning_flag && nx.low_warning_irq_enable) ||
			(|(nx.int_status & nx.int_mask));

		// read mux, unmapped addresses read zero
		unique case (addr)
			LVPM_OFS_CTL1: begin
				rd_mux[LVPM_C1_WARN_FLAG] = st.low_warning_flag;
				rd_mux[LVPM_C1_WARN_IE] = st.low_warning_irq_enable;
				rd_mux[LVPM_C1_DET_RE] = st.low_detect_reset_enable;
				rd_mux[LVPM_C1_DET_SE] = st.low_detect_stop_enable;
				rd_mux[LVPM_C1_DET_EN] = st.low_detect_enable;
				rd_mux[LVPM_C1_BG_EN] = st.bandgap_buffer_enable;
			end
			LVPM_OFS_CTL2: begin
				rd_mux[LVPM_C2_DET_VSEL] = st.detect_voltage_select;
				rd_mux[LVPM_C2_WARN_VSEL] = st.warning_voltage_select;
				rd_mux[LVPM_C2_PPD_FLAG] = st.partial_powerdown_flag;
				rd_mux[LVPM_C2_PPD_CTL] = st.partial_powerdown_control;
			end
			LVPM_OFS_ISTAT: begin
				rd_mux[LVPM_IRQ_W-1:0] = st.int_status;
			end
			LVPM_OFS_IMASK: begin
				rd_mux[LVPM_IRQ_W-1:0] = st.int_mask;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
		nx.rd_data = rd_en ? rd_mux : 8'h00;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st.warn_meta <= 1'b0;
			st.warn_sync <= 1'b0;
			st.det_meta <= 1'b0;
			st.det_sync <= 1'b0;
			st.warn_prev <= 1'b0;
			st.det_prev <= 1'b0;
			st.low_warning_flag <= 1'b0;
			st.low_warning_irq_enable <= LVPM_RST_WARN_IE;
			st.low_detect_reset_enable <= LVPM_RST_DET_RE;
			st.low_detect_stop_enable <= LVPM_RST_DET_SE;
			st.low_detect_enable <= LVPM_RST_DET_EN;
			st.bandgap_buffer_enable <= LVPM_RST_BG_EN;
			st.partial_powerdown_flag <= LVPM_RST_CTL2[LVPM_C2_PPD_FLAG];
			st.partial_powerdown_control <= LVPM_RST_CTL2[LVPM_C2_PPD_CTL];
			st.lock_one <= 1'b0;
			st.lock_two <= 1'b0;
			st.int_status <= LVPM_RST_IRQ;
			st.int_mask <= LVPM_RST_IRQ;
			st.rd_data <= 8'h00;
			st.irq <= 1'b0;
			st.reset_req <= 1'b0;
			st.detect_active <= 1'b0;
			// voltage selects survive every reset but power-on
			if (power_on_reset) begin
				st.detect_voltage_select <= LVPM_RST_CTL2[LVPM_C2_DET_VSEL];
				st.warning_voltage_select <= LVPM_RST_CTL2[LVPM_C2_WARN_VSEL];
				st.lock_vsel <= 1'b0;
			end
		end else if (clk_en) begin
			st <= nx;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rd_data = st.rd_data;
	assign irq = st.irq;
	assign low_detect_reset_req = st.reset_req;
	assign low_detect_active = st.detect_active;
	assign bandgap_buffer_enable = st.bandgap_buffer_enable;
	assign detect_voltage_select = st.detect_voltage_select;
	assign warning_voltage_select = st.warning_voltage_select;
	assign deep_stop_select = st.partial_powerdown_control;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	property p_warn_sets;
		clk_en && st.warn_sync |=> st.low_warning_flag;
	endproperty
	a_warn_sets: assert property (p_warn_sets)
		else $error("warning flag not set under warning");

	property p_warn_sticky;
		st.low_warning_flag && !(wr_c1 && wr_data[LVPM_C1_WARN_ACK])
			|=> st.low_warning_flag;
	endproperty
	a_warn_sticky: assert property (p_warn_sticky)
		else $error("warning flag dropped without acknowledge");

	property p_ack_blocked;
		clk_en && wr_c1 && wr_data[LVPM_C1_WARN_ACK] && st.warn_sync
			|=> st.low_warning_flag;
	endproperty
	a_ack_blocked: assert property (p_ack_blocked)
		else $error("warning acknowledged while still present");

	property p_ack_clears;
		clk_en && wr_c1 && wr_data[LVPM_C1_WARN_ACK] && !st.warn_sync
			|=> !st.low_warning_flag;
	endproperty
	a_ack_clears: assert property (p_ack_clears)
		else $error("warning acknowledge did not clear flag");

	property p_warn_irq;
		st.low_warning_flag && st.low_warning_irq_enable |-> irq;
	endproperty
	a_warn_irq: assert property (p_warn_irq)
		else $error("enabled warning gives no interrupt");

	property p_reset_req;
		low_detect_reset_req |-> st.low_detect_enable &&
			st.low_detect_reset_enable && $past(st.det_sync);
	endproperty
	a_reset_req: assert property (p_reset_req)
		else $error("reset request without enabled detect");

	property p_stop_off;
		clk_en && stop_mode_active && !st.low_detect_stop_enable |=> !low_detect_active;
	endproperty
	a_stop_off: assert property (p_stop_off)
		else $error("detect runs in stop while not allowed");

	property p_detect_qual;
		low_detect_active |-> st.low_detect_enable;
	endproperty
	a_detect_qual: assert property (p_detect_qual)
		else $error("detect active while disabled");

	property p_bandgap;
		clk_en && wr_c1 |=> bandgap_buffer_enable == $past(wr_data[LVPM_C1_BG_EN]);
	endproperty
	a_bandgap: assert property (p_bandgap)
		else $error("bandgap enable not written");

	property p_once_one;
		st.lock_one && wr_c1 |=> $stable(st.low_detect_enable) &&
			$stable(st.low_detect_reset_enable) && $stable(st.low_detect_stop_enable);
	endproperty
	a_once_one: assert property (p_once_one)
		else $error("locked detect bits changed");

	property p_once_vsel;
		st.lock_vsel && wr_c2 |=> $stable(detect_voltage_select);
	endproperty
	a_once_vsel: assert property (p_once_vsel)
		else $error("locked detect voltage select changed");

	property p_keep_vsel;
		@(posedge mclk) disable iff (1'b0) !reset_n && !power_on_reset |=>
			$stable(detect_voltage_select) && $stable(warning_voltage_select);
	endproperty
	a_keep_vsel: assert property (p_keep_vsel)
		else $error("voltage select lost on warm reset");

	property p_por_clear;
		@(posedge mclk) disable iff (1'b0) !reset_n && power_on_reset |=>
			!detect_voltage_select && !warning_voltage_select && !st.lock_vsel;
	endproperty
	a_por_clear: assert property (p_por_clear)
		else $error("power-on reset left control two bits");

	property p_wvsel;
		clk_en && wr_c2 |=> warning_voltage_select == $past(wr_data[LVPM_C2_WARN_VSEL]);
	endproperty
	a_wvsel: assert property (p_wvsel)
		else $error("warning voltage select not written");

	property p_ppd_set;
		clk_en && deep_stop_wake ##1 rd_en && addr == LVPM_OFS_CTL2
			|=> rd_data[LVPM_C2_PPD_FLAG];
	endproperty
	a_ppd_set: assert property (p_ppd_set)
		else $error("power-down flag not read after wake");

	property p_ppd_ack;
		clk_en && wr_c2 && wr_data[LVPM_C2_PPD_ACK] && !deep_stop_wake
			|=> !st.partial_powerdown_flag && !rd_data[LVPM_C2_PPD_ACK];
	endproperty
	a_ppd_ack: assert property (p_ppd_ack)
		else $error("power-down acknowledge failed");

	property p_partial_powerdown_control;
		clk_en && wr_c2 && !st.lock_two |=>
			deep_stop_select == $past(wr_data[LVPM_C2_PPD_CTL]) ##1 $stable(deep_stop_select);
	endproperty
	a_partial_powerdown_control: assert property (p_partial_powerdown_control)
		else $error("stop mode choice not taken once");

	property p_once_two;
		st.lock_two && wr_c2 |=> $stable(deep_stop_select);
	endproperty
	a_once_two: assert property (p_once_two)
		else $error("locked stop mode choice changed");

	property p_ppd_sticky;
		st.partial_powerdown_flag && !(wr_c2 && wr_data[LVPM_C2_PPD_ACK])
			|=> st.partial_powerdown_flag;
	endproperty
	a_ppd_sticky: assert property (p_ppd_sticky)
		else $error("power-down flag dropped without acknowledge");

	property p_ack_reads_zero;
		clk_en && rd_en && addr == LVPM_OFS_CTL2 |=> !rd_data[LVPM_C2_PPD_ACK];
	endproperty
	a_ack_reads_zero: assert property (p_ack_reads_zero)
		else $error("power-down acknowledge bit read as one");

	property p_irq_quiet;
		!(st.low_warning_flag && st.low_warning_irq_enable) &&
			!(|(st.int_status & st.int_mask)) |-> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet)
		else $error("interrupt without an enabled source");

	property p_rd_idle;
		clk_en && !rd_en |=> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data held beyond one cycle");

	c_warn_cycle: cover property (st.low_warning_flag ##[1:20] !st.low_warning_flag);
	c_reset_req: cover property (low_detect_reset_req);
	c_ppd_wake: cover property (deep_stop_wake ##1 st.partial_powerdown_flag);
	c_once_ignored: cover property (st.lock_one && wr_c1 && clk_en);

endmodule

// ### rtl/lvpm_pkg.sv
package lvpm_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int LVPM_ADDR_W = 4;
	localparam logic [LVPM_ADDR_W-1:0] LVPM_OFS_CTL1 = 4'h0;
	localparam logic [LVPM_ADDR_W-1:0] LVPM_OFS_CTL2 = 4'h1;
	localparam logic [LVPM_ADDR_W-1:0] LVPM_OFS_ISTAT = 4'h2;
	localparam logic [LVPM_ADDR_W-1:0] LVPM_OFS_IMASK = 4'h3;

	// ----------------------------------------------------------------
	// power_mgmt_status_control_one fields
	// ----------------------------------------------------------------
	localparam int LVPM_C1_WARN_FLAG = 7;
	localparam int LVPM_C1_WARN_ACK = 6;
	localparam int LVPM_C1_WARN_IE = 5;
	localparam int LVPM_C1_DET_RE = 4;
	localparam int LVPM_C1_DET_SE = 3;
	localparam int LVPM_C1_DET_EN = 2;
	localparam int LVPM_C1_BG_EN = 0;

	// reset values of the control-one bits
	localparam logic LVPM_RST_WARN_IE = 1'b0;
	localparam logic LVPM_RST_DET_RE = 1'b1;
	localparam logic LVPM_RST_DET_SE = 1'b1;
	localparam logic LVPM_RST_DET_EN = 1'b1;
	localparam logic LVPM_RST_BG_EN = 1'b0;

	// ----------------------------------------------------------------
	// power_mgmt_status_control_two fields
	// ----------------------------------------------------------------
	localparam int LVPM_C2_DET_VSEL = 5;
	localparam int LVPM_C2_WARN_VSEL = 4;
	localparam int LVPM_C2_PPD_FLAG = 3;
	localparam int LVPM_C2_PPD_ACK = 2;
	localparam int LVPM_C2_PPD_CTL = 0;
	localparam logic [7:0] LVPM_RST_CTL2 = 8'h00;

	// ----------------------------------------------------------------
	// interrupt status and mask layout
	// ----------------------------------------------------------------
	localparam int LVPM_IRQ_W = 3;
	localparam int LVPM_EV_WARN = 0;
	localparam int LVPM_EV_DETECT = 1;
	localparam int LVPM_EV_PPD = 2;
	localparam logic [LVPM_IRQ_W-1:0] LVPM_RST_IRQ = 3'h0;

	// ----------------------------------------------------------------
	// block state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic warn_meta;
		logic warn_sync;
		logic det_meta;
		logic det_sync;
		logic warn_prev;
		logic det_prev;
		logic low_warning_flag;
		logic low_warning_irq_enable;
		logic low_detect_reset_enable;
		logic low_detect_stop_enable;
		logic low_detect_enable;
		logic bandgap_buffer_enable;
		logic detect_voltage_select;
		logic warning_voltage_select;
		logic partial_powerdown_flag;
		logic partial_powerdown_control;
		logic lock_one;
		logic lock_two;
		logic lock_vsel;
		logic [LVPM_IRQ_W-1:0] int_status;
		logic [LVPM_IRQ_W-1:0] int_mask;
		logic [7:0] rd_data;
		logic irq;
		logic reset_req;
		logic detect_active;
	} lvpm_state_t;

endpackage

// ### test/lvpm_regs_test.sv
`timescale 1ns/1ps
module lvpm_regs_test;
	import lvpm_pkg::*;

	// ----------------------------------------------------------------
	// clock, stimulus and counters
	// ----------------------------------------------------------------
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic power_on_reset = 1'b1;
	logic [LVPM_ADDR_W-1:0] addr = '0;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic warning_below = 1'b0;
	logic detect_below = 1'b0;
	logic stop_mode_active = 1'b0;
	logic deep_stop_wake = 1'b0;
	logic irq;
	logic low_detect_reset_req;
	logic low_detect_active;
	logic bandgap_buffer_enable;
	logic detect_voltage_select;
	logic warning_voltage_select;
	logic deep_stop_select;
	int err_total = 0;
	int compares = 0;
	logic [31:0] seed = 32'h00001AA6;
	logic [7:0] d;
	logic wv;

	always #25 mclk = ~mclk;

	lvpm_regs i_lvpm_regs (
		.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .power_on_reset(power_on_reset),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.warning_below(warning_below), .detect_below(detect_below),
		.stop_mode_active(stop_mode_active), .deep_stop_wake(deep_stop_wake), .irq(irq),
		.low_detect_reset_req(low_detect_reset_req), .low_detect_active(low_detect_active),
		.bandgap_buffer_enable(bandgap_buffer_enable),
		.detect_voltage_select(detect_voltage_select),
		.warning_voltage_select(warning_voltage_select), .deep_stop_select(deep_stop_select)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	// expected control-one image; ack and unused bits read 0
	function automatic logic [7:0] c1(input logic f, ie, re, se, en, bg);
		return {f, 1'b0, ie, re, se, en, 1'b0, bg};
	endfunction

	task automatic test_done();
		$display("counts: compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(negedge mclk);
		chk(rd_data, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic do_reset(input logic por);
		@(posedge mclk);
		reset_n <= 1'b0;
		power_on_reset <= por;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		power_on_reset <= 1'b0;
	endtask

	task automatic wake();
		@(posedge mclk);
		deep_stop_wake <= 1'b1;
		@(posedge mclk);
		deep_stop_wake <= 1'b0;
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 10) begin
			@(negedge mclk);
			n++;
		end
		if (irq !== 1'b1) begin
			err_total++;
			$display("[FAIL] t=%0t interrupt wait ran out", $time);
			test_done();
		end
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		test_done();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset(1'b1);
		rd(4'h0, c1(0, 0, 1, 1, 1, 0));
		rd(4'h1, 8'h00);
		rd(4'h5, 8'h00);
		chk({7'h00, low_detect_active}, 8'h01);
		$display("test reset values done");

		wr(4'h0, 8'h3D);
		rd(4'h0, c1(0, 1, 1, 1, 1, 1));
		chk({7'h00, bandgap_buffer_enable}, 8'h01);
		wr(4'h0, 8'h00);
		rd(4'h0, c1(0, 0, 1, 1, 1, 0));
		for (int i = 0; i < 6; i++) begin
			d = rnd();
			wr(4'h0, d & 8'hBF);
			rd(4'h0, c1(0, d[5], 1, 1, 1, d[0]));
			chk({7'h00, bandgap_buffer_enable}, {7'h00, d[0]});
		end
		wr(4'h0, 8'h20);
		$display("test write once done");

		warning_below <= 1'b1;
		cyc(4);
		rd(4'h0, c1(1, 1, 1, 1, 1, 0));
		wait_irq();
		wr(4'h0, 8'h60);
		rd(4'h0, c1(1, 1, 1, 1, 1, 0));
		@(posedge mclk);
		warning_below <= 1'b0;
		cyc(4);
		rd(4'h0, c1(1, 1, 1, 1, 1, 0));
		wr(4'h0, 8'h60);
		rd(4'h0, c1(0, 1, 1, 1, 1, 0));
		chk({7'h00, irq}, 8'h00);
		wr(4'h0, 8'h00);
		warning_below <= 1'b1;
		cyc(4);
		chk({7'h00, irq}, 8'h00);
		@(posedge mclk);
		warning_below <= 1'b0;
		cyc(4);
		wr(4'h0, 8'h40);
		rd(4'h0, c1(0, 0, 1, 1, 1, 0));
		$display("test warning done");
		@(posedge mclk);

		detect_below <= 1'b1;
		cyc(4);
		chk({7'h00, low_detect_reset_req}, 8'h01);
		@(posedge mclk);
		stop_mode_active <= 1'b1;
		cyc(2);
		chk({7'h00, low_detect_active}, 8'h01);
		@(posedge mclk);
		stop_mode_active <= 1'b0;
		detect_below <= 1'b0;
		cyc(4);
		chk({7'h00, low_detect_reset_req}, 8'h00);
		$display("test detect done");

		wr(4'h1, 8'h31);
		rd(4'h1, 8'h31);
		chk({7'h00, detect_voltage_select}, 8'h01);
		chk({7'h00, warning_voltage_select}, 8'h01);
		chk({7'h00, deep_stop_select}, 8'h01);
		wr(4'h1, 8'h00);
		rd(4'h1, 8'h21);
		chk({7'h00, deep_stop_select}, 8'h01);
		for (int i = 0; i < 6; i++) begin
			d = rnd();
			wv = d[4];
			wr(4'h1, d & 8'hF3);
			rd(4'h1, 8'h21 | {3'h0, wv, 4'h0});
			chk({7'h00, warning_voltage_select}, {7'h00, wv});
		end
		wake();
		cyc(2);
		rd(4'h1, 8'h29 | {3'h0, wv, 4'h0});
		wr(4'h1, {3'h0, wv, 4'h4});
		rd(4'h1, 8'h21 | {3'h0, wv, 4'h0});
		$display("test control two done");

		wr(4'h2, 8'h07);
		rd(4'h2, 8'h00);
		wr(4'h3, 8'h04);
		rd(4'h3, 8'h04);
		wake();
		wait_irq();
		rd(4'h2, 8'h04);
		wr(4'h2, 8'h04);
		cyc(2);
		chk({7'h00, irq}, 8'h00);
		wr(4'h3, 8'h00);
		$display("test interrupt done");

		warning_below <= 1'b1;
		do_reset(1'b0);
		cyc(4);
		rd(4'h0, c1(1, 0, 1, 1, 1, 0));
		rd(4'h1, 8'h20 | {3'h0, wv, 4'h0});
		wr(4'h1, 8'h00);
		rd(4'h1, 8'h20);
		chk({7'h00, deep_stop_select}, 8'h00);
		wr(4'h0, 8'h04);
		rd(4'h0, c1(1, 0, 0, 0, 1, 0));
		@(posedge mclk);
		detect_below <= 1'b1;
		stop_mode_active <= 1'b1;
		cyc(4);
		chk({7'h00, low_detect_reset_req}, 8'h00);
		chk({7'h00, low_detect_active}, 8'h00);
		@(posedge mclk);
		clk_en <= 1'b0;
		wr(4'h0, 8'h01);
		@(posedge mclk);
		clk_en <= 1'b1;
		cyc(1);
		chk({7'h00, bandgap_buffer_enable}, 8'h00);
		$display("test other reset done");
		@(posedge mclk);

		warning_below <= 1'b0;
		detect_below <= 1'b0;
		stop_mode_active <= 1'b0;
		do_reset(1'b1);
		rd(4'h1, 8'h00);
		wr(4'h0, 8'h10);
		detect_below <= 1'b1;
		cyc(4);
		chk({7'h00, low_detect_reset_req}, 8'h00);
		chk({7'h00, low_detect_active}, 8'h00);
		$display("test power-on reset done");
		test_done();
	end
endmodule
